// ### src/jt_tap.v
// Boundary-scan test access port: controller, instruction decode, bypass,
// identification and boundary scan registers, pin control.
// Assumes test pins are asynchronous to mclk_i; test clock far slower.
`timescale 1ns/1ps
`include "jt_regs.vh"

// Behaviour
// - Bypass code 6'h3f puts a one-stage register between data in and data out.
// - Clamp code 6'h02 drives pins from held boundary values and shifts through bypass.
// - External-test code 6'h00 selects the 161-cell boundary register and drives pins from it.
// - High-impedance code 6'h05 turns every output off and shifts through bypass.
// - Sample/preload code 6'h01 snapshots pins without disturbing them and loads the cells.
// - Identification code 6'h20 shifts out a 32-bit word with version, family, maker and a 1.
// - User code 6'h25 shifts out a second 32-bit word with part number and its own version.
// - Any other instruction code is reserved.
// - Each pin has an observing cell and each output can be driven from a cell.
// - Each two-way pin has input, output and control cells.
// - Test reset or an update with no new instruction loads the identification code; unused codes act as bypass.
// - The port has an asynchronous test reset, held low when the port is unused.
module jt_tap #(
    parameter NI = 40,
    parameter NO = 40,
    parameter NB = 27,
    parameter [3:0] ID_VER = 4'h1, // Arbitrary value
    parameter [15:0] ID_FAMILY = 16'h0001, // Arbitrary value
    parameter [3:0] UC_VER = 4'h3, // Arbitrary value
    parameter [15:0] UC_PART = 16'h0003, // Arbitrary value
    parameter [10:0] ID_MFR = 11'h001 // Arbitrary value
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    input wire trstn_i,
    output wire tdo_o,
    output wire tdo_oen_o,
    input wire [NI-1:0] pin_in_i,
    input wire [NO-1:0] core_out_i,
    output reg [NO-1:0] pin_out_o,
    output reg [NO-1:0] pin_oen_o,
    input wire [NB-1:0] bd_pad_i,
    input wire [NB-1:0] core_bd_do_i,
    input wire [NB-1:0] core_bd_oen_i,
    output reg [NB-1:0] bd_do_o,
    output reg [NB-1:0] bd_oen_o,
    output wire [`JT_IR_W-1:0] instr_o
);

    // ------------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------------
    localparam [3:0] S_TLR = 4'hf;
    localparam [3:0] S_RTI = 4'hc;
    localparam [3:0] S_SELDR = 4'h7;
    localparam [3:0] S_CAPDR = 4'h6;
    localparam [3:0] S_SHDR = 4'h2;
    localparam [3:0] S_EX1DR = 4'h1;
    localparam [3:0] S_PADR = 4'h3;
    localparam [3:0] S_EX2DR = 4'h0;
    localparam [3:0] S_UPDR = 4'h5;
    localparam [3:0] S_SELIR = 4'h4;
    localparam [3:0] S_CAPIR = 4'he;
    localparam [3:0] S_SHIR = 4'ha;
    localparam [3:0] S_EX1IR = 4'h9;
    localparam [3:0] S_PAIR = 4'hb;
    localparam [3:0] S_EX2IR = 4'h8;
    localparam [3:0] S_UPIR = 4'hd;
    localparam LEN = NI + NO + 3 * NB;

    localparam [`JT_ID_W-1:0] IDCODE_WORD = {ID_VER, ID_FAMILY, ID_MFR, 1'b1};
    localparam [`JT_ID_W-1:0] USERCODE_WORD = {UC_VER, UC_PART, ID_MFR, 1'b1};

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg [3:0] tp_m_r;
    reg [3:0] tp_s_r;
    reg tck_d_r;
    reg [NI-1:0] pin_m_r;
    reg [NI-1:0] pin_s_r;
    reg [NB-1:0] pad_m_r;
    reg [NB-1:0] pad_s_r;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire trstn_s;
    wire tck_rise;
    wire tck_fall;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tp_m_r <= 4'h0;
            tp_s_r <= 4'h0;
            tck_d_r <= 1'b0;
            pin_m_r <= {NI{1'b0}};
            pin_s_r <= {NI{1'b0}};
            pad_m_r <= {NB{1'b0}};
            pad_s_r <= {NB{1'b0}};
        end else begin
            tp_m_r <= {trstn_i, tdi_i, tms_i, tck_i};
            tp_s_r <= tp_m_r;
            tck_d_r <= tp_s_r[0];
            pin_m_r <= pin_in_i;
            pin_s_r <= pin_m_r;
            pad_m_r <= bd_pad_i;
            pad_s_r <= pad_m_r;
        end
    end

    assign tck_s = tp_s_r[0];
    assign tms_s = tp_s_r[1];
    assign tdi_s = tp_s_r[2];
    assign trstn_s = tp_s_r[3];
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    // ------------------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------------------
    reg [3:0] st_r;
    reg [3:0] st_nxt;
    reg pend_r;
    wire step;

    // A full output buffer holds off the controller for the stalled edge
    assign step = tck_rise & ~pend_r;

    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_TLR: st_nxt = tms_s ? S_TLR : S_RTI;
            S_RTI: st_nxt = tms_s ? S_SELDR : S_RTI;
            S_SELDR: st_nxt = tms_s ? S_SELIR : S_CAPDR;
            S_CAPDR: st_nxt = tms_s ? S_EX1DR : S_SHDR;
            S_SHDR: st_nxt = tms_s ? S_EX1DR : S_SHDR;
            S_EX1DR: st_nxt = tms_s ? S_UPDR : S_PADR;
            S_PADR: st_nxt = tms_s ? S_EX2DR : S_PADR;
            S_EX2DR: st_nxt = tms_s ? S_UPDR : S_SHDR;
            S_UPDR: st_nxt = tms_s ? S_SELDR : S_RTI;
            S_SELIR: st_nxt = tms_s ? S_TLR : S_CAPIR;
            S_CAPIR: st_nxt = tms_s ? S_EX1IR : S_SHIR;
            S_SHIR: st_nxt = tms_s ? S_EX1IR : S_SHIR;
            S_EX1IR: st_nxt = tms_s ? S_UPIR : S_PAIR;
            S_PAIR: st_nxt = tms_s ? S_EX2IR : S_PAIR;
            S_EX2IR: st_nxt = tms_s ? S_UPIR : S_SHIR;
            S_UPIR: st_nxt = tms_s ? S_SELDR : S_RTI;
            default: st_nxt = S_TLR;
        endcase
    end

    // ------------------------------------------------------------------------
    // Instruction register and decode
    // ------------------------------------------------------------------------
    reg [`JT_IR_W-1:0] ir_r;
    reg [`JT_IR_W-1:0] irs_r;
    reg ir_new_r;
    reg sel_bsr;
    reg sel_id;
    reg sel_uc;

    assign instr_o = ir_r;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= S_TLR;
            ir_r <= `JT_IR_IDCODE;
            irs_r <= `JT_IR_CAPTURE;
            ir_new_r <= 1'b0;
        end else if (!trstn_s) begin
            st_r <= S_TLR;
            ir_r <= `JT_IR_IDCODE;
            ir_new_r <= 1'b0;
        end else if (step) begin
            st_r <= st_nxt;
            if (st_r == S_TLR) begin
                ir_r <= `JT_IR_IDCODE;
            end
            if (st_r == S_CAPIR) begin
                irs_r <= `JT_IR_CAPTURE;
                ir_new_r <= 1'b0;
            end else if (st_r == S_SHIR) begin
                irs_r <= {tdi_s, irs_r[`JT_IR_W-1:1]};
                ir_new_r <= 1'b1;
            end else if (st_r == S_UPIR) begin
                ir_r <= ir_new_r ? irs_r : `JT_IR_IDCODE;
                ir_new_r <= 1'b0;
            end
        end
    end

    // Reserved codes fall through to the bypass path
    always @* begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        sel_uc = 1'b0;
        if (ir_r == `JT_IR_EXTEST || ir_r == `JT_IR_SAMPLE) begin
            sel_bsr = 1'b1;
        end else if (ir_r == `JT_IR_IDCODE) begin
            sel_id = 1'b1;
        end else if (ir_r == `JT_IR_USERCODE) begin
            sel_uc = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Bypass and identification registers
    // ------------------------------------------------------------------------
    reg byp_r;
    reg [`JT_ID_W-1:0] id_r;
    wire cap_dr;
    wire sh_dr;

    assign cap_dr = step & (st_r == S_CAPDR);
    assign sh_dr = step & (st_r == S_SHDR);

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            byp_r <= 1'b0;
            id_r <= {`JT_ID_W{1'b0}};
        end else begin
            if (cap_dr) begin
                byp_r <= 1'b0;
            end else if (sh_dr) begin
                byp_r <= tdi_s;
            end
            if (cap_dr) begin
                id_r <= sel_uc ? USERCODE_WORD : IDCODE_WORD;
            end else if (sh_dr) begin
                id_r <= {tdi_s, id_r[`JT_ID_W-1:1]};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Boundary scan register: inputs, outputs, then in/out/control per pin
    // ------------------------------------------------------------------------
    wire [LEN-1:0] bs_cap;
    wire [LEN-1:0] bs_upd;
    wire bs_so;

    assign bs_cap[NI-1:0] = pin_s_r;
    assign bs_cap[NI+NO-1:NI] = pin_oen_o[0] ? core_out_i : pin_out_o;

    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : g_bidir
            assign bs_cap[NI+NO+3*g] = pad_s_r[g];
            assign bs_cap[NI+NO+3*g+1] = bd_do_o[g];
            assign bs_cap[NI+NO+3*g+2] = bd_oen_o[g];
        end
    endgenerate

    jt_bscan #(
        .LEN(LEN)
    ) u_bsr (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .capture_i(cap_dr & sel_bsr),
        .shift_i(sh_dr & sel_bsr),
        .update_i(step & (st_r == S_UPDR) & sel_bsr),
        .tdi_i(tdi_s),
        .cap_i(bs_cap),
        .so_o(bs_so),
        .upd_o(bs_upd)
    );

    // ------------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------------
    wire drive_bs;
    wire highz;
    integer k;

    assign drive_bs = (ir_r == `JT_IR_EXTEST) | (ir_r == `JT_IR_CLAMP);
    assign highz = (ir_r == `JT_IR_HIGHZ);

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_out_o <= {NO{1'b0}};
            pin_oen_o <= {NO{1'b1}};
            bd_do_o <= {NB{1'b0}};
            bd_oen_o <= {NB{1'b1}};
        end else begin
            for (k = 0; k < NO; k = k + 1) begin
                pin_out_o[k] <= drive_bs ? bs_upd[NI+k] : core_out_i[k];
                pin_oen_o[k] <= highz;
            end
            for (k = 0; k < NB; k = k + 1) begin
                bd_do_o[k] <= drive_bs ? bs_upd[NI+NO+3*k+1] : core_bd_do_i[k];
                bd_oen_o[k] <= highz | (drive_bs ? bs_upd[NI+NO+3*k+2] : core_bd_oen_i[k]);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Data out: bit queued after each rising edge, launched on the falling one
    // ------------------------------------------------------------------------
    reg rise_d_r;
    reg so_bit;
    reg out_en_r;
    reg tdo_r;
    wire shifting;
    wire q_ready;
    wire q_valid;
    wire [1:0] q_data;

    assign shifting = (st_r == S_SHDR) | (st_r == S_SHIR);

    always @* begin
        if (st_r == S_SHIR) begin
            so_bit = irs_r[0];
        end else if (sel_bsr) begin
            so_bit = bs_so;
        end else if (sel_id | sel_uc) begin
            so_bit = id_r[0];
        end else begin
            so_bit = byp_r;
        end
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rise_d_r <= 1'b0;
            pend_r <= 1'b0;
            tdo_r <= 1'b0;
            out_en_r <= 1'b1;
        end else begin
            rise_d_r <= step;
            pend_r <= (rise_d_r | pend_r) & ~q_ready;
            if (tck_fall & q_valid) begin
                tdo_r <= q_data[0];
                out_en_r <= q_data[1];
            end
        end
    end

    jt_skid #(
        .W(2),
        .DEPTH(2),
        .AW(1)
    ) u_q (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_valid_i(rise_d_r | pend_r),
        .in_ready_o(q_ready),
        .in_data_i({~shifting, so_bit}),
        .out_valid_o(q_valid),
        .out_ready_i(tck_fall),
        .out_data_o(q_data)
    );

    assign tdo_o = tdo_r;
    assign tdo_oen_o = out_en_r;

endmodule // jt_tap

// ### src/jt_regs.vh
// Constants of the boundary-scan test access logic: instruction codes,
// register widths and the instruction capture pattern.
// Assumes inclusion by bare name from the design files.
`ifndef JT_REGS_VH
`define JT_REGS_VH

// ----------------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------------
`define JT_IR_W 6
`define JT_IR_EXTEST 6'h00
`define JT_IR_SAMPLE 6'h01
`define JT_IR_CLAMP 6'h02
`define JT_IR_HIGHZ 6'h05
`define JT_IR_IDCODE 6'h20
`define JT_IR_USERCODE 6'h25
`define JT_IR_BYPASS 6'h3f
`define JT_IR_CAPTURE 6'h01

// ----------------------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------------------
`define JT_BSR_LEN 161
`define JT_ID_W 32
`define JT_ID_VER_MSB 31
`define JT_ID_VER_LSB 28
`define JT_ID_PART_MSB 27
`define JT_ID_PART_LSB 12
`define JT_ID_MFR_MSB 11
`define JT_ID_MFR_LSB 1

`endif

// ### src/jt_skid.v
// Small FIFO with valid/ready on both sides, used in the test data out path.
// Assumes a single clock; a full FIFO drops in_ready_o and the writer waits.
`timescale 1ns/1ps

module jt_skid #(
    parameter W = 2,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);

    reg [W-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    integer i;

    assign in_ready_o = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_r[i] <= {W{1'b0}};
            end
        end else begin
            if (push) begin
                mem_r[wr_r] <= in_data_i;
                wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule // jt_skid

// ### src/jt_bscan.v
// Boundary scan register: a shared capture/shift stage and an update stage per cell.
// Assumes capture, shift and update strobes are one-cycle pulses on mclk_i.
`timescale 1ns/1ps

module jt_bscan #(
    parameter LEN = 161
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire capture_i,
    input wire shift_i,
    input wire update_i,
    input wire tdi_i,
    input wire [LEN-1:0] cap_i,
    output wire so_o,
    output wire [LEN-1:0] upd_o
);

    reg [LEN-1:0] sh_r;
    reg [LEN-1:0] upd_r;
    wire [LEN:0] chain;

    assign chain[LEN] = tdi_i;
    assign so_o = sh_r[0];
    assign upd_o = upd_r;

    genvar g;
    generate
        for (g = 0; g < LEN; g = g + 1) begin : g_cell
            assign chain[g] = sh_r[g];
            always @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sh_r[g] <= 1'b0;
                    upd_r[g] <= 1'b0;
                end else begin
                    if (capture_i) begin
                        sh_r[g] <= cap_i[g];
                    end else if (shift_i) begin
                        sh_r[g] <= chain[g+1];
                    end
                    if (update_i) begin
                        upd_r[g] <= sh_r[g];
                    end
                end
            end
        end
    endgenerate

endmodule // jt_bscan

// ### verif/jt_tap_asserts.sv
// Port checks of the boundary-scan access logic.
// Assumes binding to jt_tap; pins follow an instruction one mclk late.
`timescale 1ns/1ps

module jt_tap_asserts #(
    parameter NI = 40,
    parameter NO = 40,
    parameter NB = 27
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    input wire trstn_i,
    input wire tdo_o,
    input wire tdo_oen_o,
    input wire [NI-1:0] pin_in_i,
    input wire [NO-1:0] core_out_i,
    input wire [NO-1:0] pin_out_o,
    input wire [NO-1:0] pin_oen_o,
    input wire [NB-1:0] bd_pad_i,
    input wire [NB-1:0] core_bd_do_i,
    input wire [NB-1:0] core_bd_oen_i,
    input wire [NB-1:0] bd_do_o,
    input wire [NB-1:0] bd_oen_o,
    input wire [5:0] instr_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    // Core keeps the pins under every instruction but external test, clamp and high-z
    wire core_w = (instr_o != 6'h00) && (instr_o != 6'h02) && (instr_o != 6'h05);

    // ------------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------------
    AST_FOLLOW_CORE: assert property ($past(rstn_i) && core_w && $past(core_w)
        |-> pin_out_o == $past(core_out_i) && pin_oen_o == '0)
        else $error("output pins do not follow the core");
    AST_BD_FOLLOW: assert property ($past(rstn_i) && core_w && $past(core_w)
        |-> bd_do_o == $past(core_bd_do_i) && bd_oen_o == $past(core_bd_oen_i))
        else $error("two-way pins do not follow the core");
    AST_HIGHZ_OFF: assert property (instr_o == 6'h05 && $past(instr_o) == 6'h05
        |-> &pin_oen_o && &bd_oen_o)
        else $error("an output stays enabled under high-z");
    AST_CLAMP_HOLD: assert property ((instr_o == 6'h02) [*3]
        |-> $stable(pin_out_o) && $stable(bd_do_o) && $stable(bd_oen_o))
        else $error("clamped pins changed");
    AST_EXTEST_EN: assert property ((instr_o == 6'h00) [*2] |-> pin_oen_o == '0)
        else $error("outputs not enabled under external test");

    // ------------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------------
    AST_TDO_FALL: assert property ($changed(tdo_o) || $changed(tdo_oen_o)
        |-> !$past(tck_i, 2) && !$past(tck_i, 3))
        else $error("data out moved away from a falling test clock");
    AST_TDO_HOLD: assert property (tck_i [*4] |-> $stable(tdo_o))
        else $error("data out moved while test clock high");
    AST_TRST_IR: assert property ((!trstn_i) [*6] |-> instr_o == 6'h20)
        else $error("test reset did not select identification");
    AST_TRST_OEN: assert property ((!trstn_i) [*6] |-> tdo_oen_o)
        else $error("data out driven during test reset");

    C_EXTEST: cover property (instr_o == 6'h00 && pin_out_o != core_out_i);
    C_HIGHZ: cover property (instr_o == 6'h05 && &pin_oen_o);
    C_SHIFT: cover property (!tdo_oen_o && tdo_o);
endmodule // jt_tap_asserts

// ### verif/jt_tester.sv
// Boundary-scan tester model driving the serial test port.
// Assumes tasks are called at a rising mclk edge; tck period is 8 mclk.
`timescale 1ns/1ps

module jt_tester (
    input wire mclk_i,
    input wire tdo_i,
    input wire tdo_oen_i,
    output reg tck_o,
    output reg tms_o,
    output reg tdi_o,
    output reg trstn_o
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trstn_o = 1'b0;
    end

    task set_trst(input logic v);
        trstn_o <= v;
    endtask

    // Data out is read half an mclk before the falling edge; released data out reads inverted
    task step(input logic m, input logic d, output logic o);
        begin
            tms_o <= m;
            tdi_o <= d;
            repeat (4) @(posedge mclk_i);
            tck_o <= 1'b1;
            repeat (3) @(posedge mclk_i);
            @(negedge mclk_i);
            o = tdo_oen_i ? ~tdo_i : tdo_i;
            @(posedge mclk_i);
            tck_o <= 1'b0;
        end
    endtask

    // Idle data in toggles so a stale level is never mistaken for data
    task mv(input logic m);
        logic o;
        step(m, ~tdi_o, o);
    endtask

    task reset_tap;
        begin
            repeat (5) mv(1'b1);
            mv(1'b0);
        end
    endtask

    // From idle: shift n bits LSB first through IR or DR, then back to idle
    task scan(input logic ir, input int n, input logic [160:0] din, output logic [160:0] dout);
        begin
            dout = '0;
            mv(1'b1);
            if (ir) mv(1'b1);
            mv(1'b0);
            mv(1'b0);
            for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
            mv(1'b1);
            mv(1'b0);
            // One more edge so the pins have followed a new instruction
            @(posedge mclk_i);
        end
    endtask

    // Instruction path walked without any shift
    task ir_skip;
        begin
            mv(1'b1);
            mv(1'b1);
            mv(1'b0);
            mv(1'b1);
            mv(1'b1);
            mv(1'b0);
        end
    endtask
endmodule // jt_tester

// ### verif/testbench.sv
// Self-checking bench of the boundary-scan access logic.
// Assumes jt_tap and its header; the tester model drives the test port.
`timescale 1ns/1ps

module testbench;
    localparam NI = 40;
    localparam NO = 40;
    localparam NB = 27;
    // Identification fields: arbitrary values
    localparam [3:0] ID_VER = 4'h6;
    localparam [15:0] ID_FAM = 16'h1234;
    localparam [3:0] UC_VER = 4'h9;
    localparam [15:0] UC_PART = 16'h4321;
    localparam [10:0] ID_MFR = 11'h155;
    localparam [160:0] PRE = {7{23'h5a3c96}};

    reg mclk_i = 1'b0;
    reg rstn_i = 1'b0;
    reg [NI-1:0] pin_in_i = 40'ha5c3_0ff0_96;
    reg [NO-1:0] core_out_i = 40'h3c_1234_e7d1;
    reg [NB-1:0] bd_pad_i = 27'h5b1_c0de;
    reg [NB-1:0] core_bd_do_i = 27'h2a5_f00d;
    reg [NB-1:0] core_bd_oen_i = 27'h0;
    wire tck_i, tms_i, tdi_i, trstn_i, tdo_o, tdo_oen_o;
    wire [NO-1:0] pin_out_o, pin_oen_o;
    wire [NB-1:0] bd_do_o, bd_oen_o;
    wire [5:0] instr_o;
    integer n_mismatch = 0;
    integer num_checks = 0;
    logic [160:0] rd;
    logic [80:0] e;
    logic [NB-1:0] f, g;

    always #25 mclk_i = ~mclk_i;

    jt_tap #(.NI(NI), .NO(NO), .NB(NB), .ID_VER(ID_VER), .ID_FAMILY(ID_FAM), .UC_VER(UC_VER),
        .UC_PART(UC_PART), .ID_MFR(ID_MFR)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .tck_i(tck_i),
        .tms_i(tms_i), .tdi_i(tdi_i), .trstn_i(trstn_i), .tdo_o(tdo_o), .tdo_oen_o(tdo_oen_o),
        .pin_in_i(pin_in_i), .core_out_i(core_out_i), .pin_out_o(pin_out_o), .pin_oen_o(pin_oen_o),
        .bd_pad_i(bd_pad_i), .core_bd_do_i(core_bd_do_i), .core_bd_oen_i(core_bd_oen_i),
        .bd_do_o(bd_do_o), .bd_oen_o(bd_oen_o), .instr_o(instr_o));

    jt_tester tstr (.mclk_i(mclk_i), .tdo_i(tdo_o), .tdo_oen_i(tdo_oen_o), .tck_o(tck_i),
        .tms_o(tms_i), .tdi_o(tdi_i), .trstn_o(trstn_i));

    task chk(input string what, input logic [160:0] exp, input logic [160:0] got);
        begin
            num_checks++;
            if (got !== exp) begin
                n_mismatch++;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task summarize;
        begin
            $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // One-stage path: first bit out is the captured 0, then data in delayed by one
    task bypass_path;
        begin
            tstr.scan(1'b0, 8, 161'hb2, rd);
            chk("bypass path", 8'h64, rd[7:0]);
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task t_ident;
        begin
            tstr.reset_tap;
            chk("instr after reset", 6'h20, instr_o);
            tstr.scan(1'b0, 32, '0, rd);
            chk("id word", {ID_VER, ID_FAM, ID_MFR, 1'b1}, rd);
            tstr.scan(1'b1, 6, 161'h25, rd);
            chk("ir capture", 6'h01, rd);
            chk("instr user", 6'h25, instr_o);
            tstr.scan(1'b0, 32, '0, rd);
            chk("user word", {UC_VER, UC_PART, ID_MFR, 1'b1}, rd);
            $display("Test ident done");
        end
    endtask

    task t_bypass;
        logic [5:0] codes [2];
        begin
            codes = '{6'h3f, 6'h11};
            foreach (codes[i]) begin
                tstr.scan(1'b1, 6, {155'h0, codes[i]}, rd);
                chk("instr bypass", codes[i], instr_o);
                bypass_path;
            end
            tstr.ir_skip;
            chk("instr no shift", 6'h20, instr_o);
            $display("Test bypass done");
        end
    endtask

    task t_extest;
        begin
            tstr.scan(1'b1, 6, 161'h01, rd);
            chk("sample pins", core_out_i, pin_out_o);
            tstr.scan(1'b0, 161, PRE, rd);
            for (int k = 0; k < NB; k++) begin
                e[3*k] = bd_pad_i[k];
                e[3*k+1] = core_bd_do_i[k];
                e[3*k+2] = core_bd_oen_i[k];
                f[k] = PRE[NI+NO+3*k+1];
                g[k] = PRE[NI+NO+3*k+2];
            end
            chk("capture", {e, core_out_i, pin_in_i}, rd);
            tstr.scan(1'b1, 6, 161'h00, rd);
            chk("extest pins", PRE[79:40], pin_out_o);
            chk("extest enables", '0, pin_oen_o);
            chk("extest bd data", f, bd_do_o);
            chk("extest bd enables", g, bd_oen_o);
            pin_in_i <= ~pin_in_i;
            repeat (4) @(posedge mclk_i);
            tstr.scan(1'b0, 161, PRE, rd);
            chk("extest inputs", pin_in_i, rd[39:0]);
            $display("Test extest done");
        end
    endtask

    task t_clamp_highz;
        begin
            tstr.scan(1'b1, 6, 161'h02, rd);
            core_out_i <= ~core_out_i;
            repeat (4) @(posedge mclk_i);
            chk("clamp pins", PRE[79:40], pin_out_o);
            chk("clamp bd data", f, bd_do_o);
            bypass_path;
            tstr.scan(1'b1, 6, 161'h05, rd);
            chk("highz enables", {NO{1'b1}}, pin_oen_o);
            chk("highz bd enables", {NB{1'b1}}, bd_oen_o);
            bypass_path;
            tstr.scan(1'b1, 6, 161'h3f, rd);
            chk("bypass pins", core_out_i, pin_out_o);
            chk("bypass enables", '0, pin_oen_o);
            $display("Test clamp highz done");
        end
    endtask

    task t_trst;
        begin
            tstr.set_trst(1'b0);
            repeat (8) @(posedge mclk_i);
            chk("instr test reset", 6'h20, instr_o);
            chk("tdo released", 1'b1, tdo_oen_o);
            tstr.set_trst(1'b1);
            repeat (4) @(posedge mclk_i);
            tstr.reset_tap;
            tstr.scan(1'b0, 32, '0, rd);
            chk("id after test reset", {ID_VER, ID_FAM, ID_MFR, 1'b1}, rd);
            $display("Test trst done");
        end
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        tstr.set_trst(1'b1);
        repeat (4) @(posedge mclk_i);
        t_ident;
        t_bypass;
        t_extest;
        t_clamp_highz;
        t_trst;
        summarize;
    end

    initial begin
        repeat (60000) @(posedge mclk_i);
        n_mismatch++;
        summarize;
    end
endmodule // testbench

bind jt_tap jt_tap_asserts #(.NI(NI), .NO(NO), .NB(NB)) u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .trstn_i(trstn_i), .tdo_o(tdo_o), .tdo_oen_o(tdo_oen_o),
    .pin_in_i(pin_in_i), .core_out_i(core_out_i), .pin_out_o(pin_out_o), .pin_oen_o(pin_oen_o),
    .bd_pad_i(bd_pad_i), .core_bd_do_i(core_bd_do_i), .core_bd_oen_i(core_bd_oen_i),
    .bd_do_o(bd_do_o), .bd_oen_o(bd_oen_o), .instr_o(instr_o));
